// file: sar6_regs.svh
/*
  Constants of the six-channel converter readout: timing counts,
  control word fields, reset values and lane frame lengths.
  Assumes the system clock runs at 125 MHz.
*/
`ifndef SAR6_REGS_SVH
`define SAR6_REGS_SVH

`define CLK_PERIOD_NS  8
`define CONV_TIME_NS   3000
`define CONV_CYCLES    (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CONV_CNT_W     9

`define WORD_BITS      16
`define CTRL_SEL_LSB   3
`define CTRL_RNG_LSB   0
`define CTRL_RESET     6'h00
`define RANGE_HW       3'h0
`define PAIRS_ALL      3'h7

`define OWN_BITS_L3    8'h20
`define OWN_BITS_L2    8'h30
`define OWN_BITS_L1    8'h60
`define POS_MAX        8'hFF
`define CAP_BITS       96

`endif

// file: sar6_pkg.sv
/*
  Types of the six-channel converter readout.
  Assumes sar6_regs.svh is on the include path.
*/
`default_nettype none

package sar6_pkg;

	typedef logic [15:0] word_type;

	typedef struct packed {
		word_type [5:0] ch;
	} results_type;

	typedef struct packed {
		logic [2:0] sel;
		logic [2:0] rng;
	} ctrl_type;

	typedef struct packed {
		logic       conv_start;
		logic       wr_n;
		logic       cs_n;
		logic [5:0] ctrl_bits;
		logic       serial_parallel_select;
		logic       chain_enable;
		logic [2:0] lane_en;
		logic       sw_mode;
	} pins_type;

	typedef enum logic [2:0] {
		LANE1 = 3'b001,
		LANE2 = 3'b010,
		LANE3 = 3'b100
	} lane_mode_type;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_RUN  = 2'b10
	} conv_state_type;

endpackage

`default_nettype wire

// file: sar6_readout.sv
/*
  Conversion control and serial readout of a six-channel simultaneous
  sampling converter, with one to three output lanes and daisy chaining.
  Assumes the analog core delivers results on i_conv_data in the i_clk
  domain, and that the host drives i_sclk idle high and reads only after
  busy has fallen, so the result store is steady while i_sclk runs.
*/
// What this block does
// - In software mode each pair's range bit picks 2xVref (1) or 4xVref (0).
// - Conv_start rising edge starts simultaneous conversion of all selected pairs.
// - Busy rises after conv_start edge and falls 3 us later.
// - At conversion end the new results load into the output store.
// - Lane enable pins pick three, two or one active output lanes.
// - Three lanes carry six results in one 32-clock or two 16-clock frames.
// - Two lanes: A carries inputs 1,2,5 and B carries 3,4,6.
// - One lane: everything on lane A in 96, 32 or 16-clock frames.
// - Chip select fall enables lanes and shows first result's MSB.
// - Each result is a 16-bit MSB-first word, short variants zero padded.
// - First bit valid at first falling edge; rest launch on rising edges.
// - Chain_enable with serial select turns three pins into chain inputs.
// - Two-lane chain: own data first 48 clocks, chained data last 48.
// - Three-lane chain: own data first 32 clocks, upstream data last 32.
// - After own and upstream data are out, lanes send zeros.
// - Chained readout may be split into 16-clock frames while chaining stays on.
// - Range bits map high to low onto pairs 5/6, 3/4, 1/2.
// - Control word captured from upper data lines on write strobe rise; resets zero.
`include "sar6_regs.svh"
`default_nettype none

module sar6_readout #(
	parameter int RES_BITS = 16
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_sclk,
	input  wire logic                   i_conv_start,
	input  wire logic                   i_cs_n,
	input  wire logic                   i_wr_n,
	input  wire logic [7:0]             i_db_hi,
	input  wire logic                   i_serial_parallel_select,
	input  wire logic                   i_chain_enable,
	input  wire logic [2:0]             i_lane_en,
	input  wire logic [2:0]             i_chain_in,
	input  wire logic                   i_sw_mode,
	input  wire sar6_pkg::results_type  i_conv_data,
	output logic                        o_busy,
	output logic                        o_sample,
	output logic [2:0]                  o_range_bit,
	output logic [2:0]                  o_pair_sel,
	output wire logic [2:0]             o_dout,
	output wire logic [2:0]             o_dout_oe
);
	import sar6_pkg::*;

	localparam int CONV_CYC = `CONV_CYCLES;
	localparam logic [16:0] MASK_W = (17'h00001 << RES_BITS) - 17'h00001;
	localparam word_type RES_MASK = MASK_W[15:0];

	if (RES_BITS != 16 && RES_BITS != 14 && RES_BITS != 12) begin : g_bad_res
		$error("RES_BITS must be 12, 14 or 16");
	end

	// Pin synchroniser, all async inputs of the system domain
	pins_type pins_w;
	pins_type sync1_ff;
	pins_type sync2_ff;

	assign pins_w = '{
		conv_start:             i_conv_start,
		wr_n:                   i_wr_n,
		cs_n:                   i_cs_n,
		ctrl_bits:              i_db_hi[7:2],
		serial_parallel_select: i_serial_parallel_select,
		chain_enable:           i_chain_enable,
		lane_en:                i_lane_en,
		sw_mode:                i_sw_mode
	};

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pins_w;
			sync2_ff <= sync1_ff;
		end
	end

	// Edge history of synchronised strobes
	logic conv_d_ff;
	logic wr_d_ff;
	logic cs_d_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			conv_d_ff <= 1'b0;
			wr_d_ff   <= 1'b1;
			cs_d_ff   <= 1'b1;
		end else begin
			conv_d_ff <= sync2_ff.conv_start;
			wr_d_ff   <= sync2_ff.wr_n;
			cs_d_ff   <= sync2_ff.cs_n;
		end
	end

	wire logic conv_rise;
	wire logic wr_rise;

	assign conv_rise = sync2_ff.conv_start & ~conv_d_ff;
	assign wr_rise   = sync2_ff.wr_n & ~wr_d_ff & ~cs_d_ff;

	// Control word: pair select and range bits
	ctrl_type ctrl_ff;
	ctrl_type nxt_ctrl;

	assign nxt_ctrl = wr_rise ? ctrl_type'(sync2_ff.ctrl_bits) : ctrl_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff <= ctrl_type'(`CTRL_RESET);
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Conversion timer
	conv_state_type state_ff;
	logic [`CONV_CNT_W-1:0] cnt_ff;
	logic busy_ff;
	logic sample_ff;
	logic rearm_ff;
	logic [2:0] range_ff;
	logic [2:0] pair_ff;

	wire logic conv_go;
	wire logic conv_done;
	wire logic [2:0] nxt_range;
	wire logic [2:0] nxt_pair;

	assign conv_go   = conv_rise & (state_ff == CONV_IDLE);
	assign conv_done = (state_ff == CONV_RUN) & (cnt_ff == '0);
	// Bit 2 is pair 5/6, bit 0 is pair 1/2
	assign nxt_range = sync2_ff.sw_mode ? ctrl_ff.rng : `RANGE_HW;
	assign nxt_pair  = sync2_ff.sw_mode ? ctrl_ff.sel : `PAIRS_ALL;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= CONV_IDLE;
			cnt_ff   <= '0;
		end else begin
			unique case (state_ff)
				CONV_IDLE: begin
					if (conv_go) begin
						state_ff <= CONV_RUN;
						cnt_ff   <= `CONV_CNT_W'(CONV_CYC - 1);
					end
				end
				CONV_RUN: begin
					if (conv_done) begin
						state_ff <= CONV_IDLE;
					end else begin
						cnt_ff <= cnt_ff - `CONV_CNT_W'(1);
					end
				end
				default: begin
					state_ff <= CONV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_ff   <= 1'b0;
			sample_ff <= 1'b0;
			rearm_ff  <= 1'b0;
			range_ff  <= '0;
			pair_ff   <= '0;
		end else begin
			busy_ff   <= conv_go | (busy_ff & ~conv_done);
			sample_ff <= conv_go;
			rearm_ff  <= conv_done;
			if (conv_go) begin
				range_ff <= nxt_range;
				pair_ff  <= nxt_pair;
			end
		end
	end

	assign o_busy      = busy_ff;
	assign o_sample    = sample_ff;
	assign o_range_bit = range_ff;
	assign o_pair_sel  = pair_ff;

	// Result store and readout mode, frozen at conversion end
	results_type results_ff;
	results_type masked_w;
	lane_mode_type mode_ff;
	lane_mode_type nxt_mode;
	logic chain_ff;
	logic ser_ff;

	for (genvar k = 0; k < 6; k++) begin : g_mask
		assign masked_w.ch[k] = i_conv_data.ch[k] & RES_MASK;
	end

	assign nxt_mode = (&sync2_ff.lane_en) ? LANE3 :
		(sync2_ff.lane_en[1] & ~sync2_ff.lane_en[2]) ? LANE2 : LANE1;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			results_ff <= '0;
			mode_ff    <= LANE1;
			chain_ff   <= 1'b0;
			ser_ff     <= 1'b0;
		end else if (conv_done) begin
			results_ff <= masked_w;
			mode_ff    <= nxt_mode;
			chain_ff   <= sync2_ff.chain_enable & sync2_ff.serial_parallel_select;
			ser_ff     <= sync2_ff.serial_parallel_select;
		end
	end

	// Link side. Store and mode are steady while the host reads, so
	// they are read here directly; the position restarts on each new result.
	wire logic link_rst;
	logic [7:0] pos_ff;
	logic [2:0][`CAP_BITS-1:0] cap_ff;

	assign link_rst = i_rst | rearm_ff;

	// Position survives chip select, so split frames continue the stream
	always_ff @(posedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			pos_ff <= '0;
		end else if (!i_cs_n && pos_ff != `POS_MAX) begin
			pos_ff <= pos_ff + 8'h01;
		end
	end

	wire logic [7:0] own_bits;
	wire logic [7:0] tail_bits;
	wire logic own_phase;
	wire logic chain_phase;
	wire logic [7:0] cap_pos;
	wire logic [2:0] lane_on;

	assign own_bits = (mode_ff == LANE3) ? `OWN_BITS_L3 :
		(mode_ff == LANE2) ? `OWN_BITS_L2 : `OWN_BITS_L1;
	assign tail_bits   = own_bits + own_bits;
	assign own_phase   = pos_ff < own_bits;
	assign chain_phase = chain_ff & ~own_phase & (pos_ff < tail_bits);
	assign cap_pos     = pos_ff - own_bits;
	assign lane_on     = (mode_ff == LANE3) ? 3'h7 : (mode_ff == LANE2) ? 3'h3 : 3'h1;

	// Upstream data is valid at the falling edge, like the host's sample
	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			cap_ff <= '0;
		end else if (!i_cs_n && chain_ff && own_phase) begin
			for (int l = 0; l < 3; l++) begin
				cap_ff[l][pos_ff[6:0]] <= i_chain_in[l];
			end
		end
	end

	function automatic logic [2:0] chan_of(lane_mode_type m, logic [1:0] lane, logic [2:0] w);
		logic [2:0] c;
		c = w;
		unique case (m)
			LANE3: c = {lane, 1'b0} + w;
			LANE2: c = (w == 3'h2) ? {2'b10, lane[0]} : {lane[0], 1'b0} + w;
			LANE1: c = w;
			default: c = w;
		endcase
		return c;
	endfunction

	// Lanes mux straight off the store so the MSB shows before any edge
	wire logic [2:0] dout_bits;

	for (genvar l = 0; l < 3; l++) begin : g_lane
		wire logic [2:0] ch;
		wire word_type word;
		assign ch   = chan_of(mode_ff, 2'(l), pos_ff[6:4]);
		assign word = results_ff.ch[ch];
		assign dout_bits[l] = ~lane_on[l] ? 1'b0 :
			own_phase ? word[4'hF - pos_ff[3:0]] :
			chain_phase ? cap_ff[l][cap_pos[6:0]] : 1'b0;
	end

	assign o_dout    = dout_bits;
	assign o_dout_oe = lane_on & {3{ser_ff & ~i_cs_n}};

	// Checks
	logic [`CONV_CNT_W-1:0] busy_len_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_len_ff <= '0;
		end else begin
			busy_len_ff <= busy_ff ? busy_len_ff + `CONV_CNT_W'(1) : '0;
		end
	end

	AST_BUSY_RISE: assert property (@(posedge i_clk) disable iff (i_rst)
		conv_rise && state_ff == CONV_IDLE |=> o_busy && o_sample ##1 !o_sample)
		else $error("busy did not start on conversion edge");

	AST_BUSY_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_busy) |-> $past(busy_len_ff) == `CONV_CNT_W'(CONV_CYC - 1))
		else $error("busy length is not the conversion time");

	AST_LOAD: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_busy) |-> results_ff == $past(masked_w))
		else $error("results not loaded at conversion end");

	AST_RANGE: assert property (@(posedge i_clk) disable iff (i_rst)
		conv_go && sync2_ff.sw_mode |=> o_range_bit == $past(ctrl_ff.rng) throughout o_busy [*2])
		else $error("range bits not taken at conversion start");

	AST_CTRL_WR: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_rise |=> ctrl_ff == $past(sync2_ff.ctrl_bits))
		else $error("control word not captured on write strobe");

	AST_RES_PAD: assert property (@(posedge i_clk) disable iff (i_rst)
		(results_ff & ~{6{RES_MASK}}) == '0)
		else $error("padding bits of a result are not zero");

	AST_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
		conv_done && sync2_ff.lane_en == 3'h3 |=> mode_ff == LANE2 && o_dout_oe[2] == 1'b0)
		else $error("two-lane straps did not select two lanes");

	AST_POS_ADV: assert property (@(posedge i_sclk) disable iff (link_rst)
		!i_cs_n && pos_ff < 8'h10 |=> pos_ff == $past(pos_ff) + 8'h01)
		else $error("link position did not advance on rising edge");

	AST_MSB_FIRST: assert property (@(negedge i_sclk) disable iff (link_rst)
		!i_cs_n && pos_ff == '0 && mode_ff == LANE3 |-> o_dout == {results_ff.ch[4][15],
		results_ff.ch[2][15], results_ff.ch[0][15]})
		else $error("first bit is not the MSB of the first result");

	AST_ZERO_TAIL: assert property (@(negedge i_sclk) disable iff (link_rst)
		!i_cs_n && pos_ff >= tail_bits |-> o_dout == 3'h0)
		else $error("lanes not zero after all data");

	COV_CONV: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_busy));

	COV_FULL_L1: cover property (@(posedge i_sclk) disable iff (link_rst)
		mode_ff == LANE1 && pos_ff == `OWN_BITS_L1);

	COV_CHAIN: cover property (@(negedge i_sclk) disable iff (link_rst)
		chain_phase && !i_cs_n);

endmodule

`default_nettype wire

// file: sar6_host.sv
/*
  Serial host model: frames a read with chip select, clocks the link
  and captures every lane on falling edges.
  Assumes the lanes launch on sclk rise and show the MSB at frame start.
*/
`default_nettype none

module sar6_host (
	input  wire logic        i_go,
	input  wire logic [6:0]  i_bits,
	input  wire logic [2:0]  i_dout,
	input  wire logic [2:0]  i_oe,
	output logic             o_sclk,
	output logic             o_cs_n,
	output logic             o_act,
	output logic [2:0]       o_oe_seen,
	output logic [2:0][95:0] o_cap
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_act = 1'b0;
		o_oe_seen = 3'h0;
		o_cap = '0;
	end

	// Sclk idles high and runs only inside a frame
	always @(posedge i_go) begin
		o_act = 1'b1;
		#3 o_cs_n = 1'b0;
		#20 o_oe_seen = i_oe;
		repeat (i_bits) begin
			o_sclk = 1'b0;
			for (int k = 0; k < 3; k++) begin
				o_cap[k] = {o_cap[k][94:0], i_dout[k]};
			end
			#24 o_sclk = 1'b1;
			#24;
		end
		o_cs_n = 1'b1;
		o_act = 1'b0;
	end
endmodule

`default_nettype wire

// file: tb_top.sv
/*
  Testbench of the six-channel readout: conversions, lane modes,
  split frames, daisy chain and control word.
  Assumes sar6_host as the serial master on a 48 ns link clock.
*/
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sar6_pkg::*;

	logic              clk, rst, conv, wr_n, wcs_n, ser, chain, sw, go;
	logic [7:0]        db;
	logic [2:0]        lane, cin;
	logic [6:0]        bits;
	results_type       data;
	wire logic         busy, sample, sclk, hcs_n, act;
	wire logic [2:0]   rng, psel, dout, oe, oe_seen;
	wire logic [2:0][95:0] cap;
	wire logic         cs_n = hcs_n & wcs_n;
	int                miscompares, tests_run;

	sar6_readout sar6_readout_i (.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_conv_start(conv),
		.i_cs_n(cs_n), .i_wr_n(wr_n), .i_db_hi(db), .i_serial_parallel_select(ser),
		.i_chain_enable(chain), .i_lane_en(lane), .i_chain_in(cin), .i_sw_mode(sw),
		.i_conv_data(data), .o_busy(busy), .o_sample(sample), .o_range_bit(rng),
		.o_pair_sel(psel), .o_dout(dout), .o_dout_oe(oe));

	sar6_host sar6_host_i (.i_go(go), .i_bits(bits), .i_dout(dout), .i_oe(oe), .o_sclk(sclk),
		.o_cs_n(hcs_n), .o_act(act), .o_oe_seen(oe_seen), .o_cap(cap));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Upstream device launches a new chain bit on each rising edge, so order errors show
	always @(posedge sclk) begin
		cin <= cin + 3'h3;
	end

	task automatic finish_test();
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic over(input int t, input int lim);
		if (t >= lim) begin
			miscompares++;
			finish_test();
		end
	endtask

	function automatic int idx(input logic [2:0] m, input int k, input int w);
		if (m == 3'h7)
			return 2 * k + w;
		if (m == 3'h3)
			return (w == 2) ? 4 + k : 2 * k + w;
		return w;
	endfunction

	// Start is ignored while busy, so a held level is safe
	task automatic convert();
		int t;
		@(posedge clk);
		conv <= 1'b1;
		t = 0;
		while (busy !== 1'b1 && t < 8) begin
			@(negedge clk);
			t++;
		end
		over(t, 8);
		check("start latency", 96'(t inside {[3:4]}), 96'h1);
		check("sample", 96'(sample), 96'h1);
		t = 0;
		while (busy === 1'b1 && t < 400) begin
			@(negedge clk);
			t++;
		end
		over(t, 400);
		check("busy cycles", 96'(t), 96'h177);
		@(posedge clk);
		conv <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic frame(input logic [6:0] n);
		int t;
		@(posedge clk);
		bits <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		t = 0;
		while (act === 1'b1 && t < 1200) begin
			@(negedge clk);
			t++;
		end
		over(t, 1200);
	endtask

	// New data per run, so a stale store shows up
	task automatic run(input logic [2:0] m, input logic ch, input int n, input int fs);
		logic [95:0] e;
		int          own;
		logic [2:0]  cv;
		@(posedge clk);
		lane <= m;
		chain <= ch;
		cin <= 3'h5;
		data <= {data[79:0], data[95:80]};
		convert();
		own = (m == 3'h7) ? 2 : (m == 3'h3) ? 3 : 6;
		for (int f = 0; f < n / fs; f++) begin
			frame(7'(fs));
		end
		for (int k = 0; k < 3; k++) begin
			e = '0;
			for (int b = 0; b < n; b++) begin
				if (b / 16 < own)
					e = {e[94:0], data.ch[idx(m, k, b / 16)][15 - b % 16]};
				else if (b / 16 < 2 * own && ch) begin
					cv = 3'h5 + 3'(3 * (b - 16 * own));
					e = {e[94:0], cv[k]};
				end else
					e = {e[94:0], 1'b0};
			end
			if (m[k])
				check("lane data", cap[k] & ((96'h1 << n) - 96'h1), e);
		end
		check("oe at first edge", 96'(oe_seen), 96'(m));
		check("oe idle", 96'(oe), 96'h0);
	endtask

	// Serial select low keeps every lane released, checked before the first edge of a frame
	task automatic parallel();
		@(posedge clk);
		ser <= 1'b0;
		convert();
		frame(7'h10);
		check("oe parallel", 96'(oe_seen), 96'h0);
		@(posedge clk);
		ser <= 1'b1;
	endtask

	task automatic ctrl(input logic [7:0] v, input logic [2:0] r, input logic [2:0] p);
		@(posedge clk);
		wcs_n <= 1'b0;
		wr_n <= 1'b0;
		db <= v;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		repeat (4) @(posedge clk);
		wcs_n <= 1'b1;
		sw <= 1'b1;
		convert();
		check("range", 96'(rng), 96'(r));
		check("pairs", 96'(psel), 96'(p));
	endtask

	initial begin
		rst = 1'b1;
		conv = 1'b0;
		wr_n = 1'b1;
		wcs_n = 1'b1;
		ser = 1'b1;
		chain = 1'b0;
		sw = 1'b0;
		go = 1'b0;
		db = 8'h00;
		lane = 3'h7;
		cin = 3'h5;
		bits = 7'h00;
		for (int i = 0; i < 6; i++)
			data.ch[i] = 16'hC3A5 ^ (16'h1357 * 16'(i));
		miscompares = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		check("reset", 96'({busy, rng, psel, oe}), 96'h0);
		run(3'h7, 1'b0, 32, 32);
		check("hw range", 96'({rng, psel}), 96'h07);
		run(3'h7, 1'b0, 32, 16);
		run(3'h3, 1'b0, 48, 48);
		run(3'h1, 1'b0, 96, 96);
		run(3'h1, 1'b0, 96, 32);
		run(3'h1, 1'b0, 96, 16);
		run(3'h7, 1'b1, 80, 80);
		run(3'h3, 1'b1, 96, 16);
		parallel();
		ctrl(8'hAC, 3'h3, 3'h5);
		ctrl(8'h50, 3'h4, 3'h2);
		finish_test();
	end
endmodule

`default_nettype wire
